// *** radio_framing_pkg.sv ***
// constants, field layouts and types for the packet framing block
package radio_framing_pkg;
    // register byte addresses on the apb port
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_TXLEN = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    // framing_config fields
    localparam int CFG_MARKER_EN = 7;
    localparam int CFG_LONG_CODE = 6;
    localparam int CFG_LENGTH_FIELD_ENABLE = 5;
    localparam int CFG_TH_HI = 4;
    localparam logic [7:0] CFG_RESET = 8'hA4;
    localparam logic [7:0] TXLEN_RESET = 8'h00;
    // control register fields
    localparam int CTRL_EIGHT_BIT = 0;
    localparam int CTRL_TX_GO = 1;
    // status register fields
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_RX_ST_LO = 2;
    localparam int STAT_RX_LEN_LO = 8;
    localparam int STAT_DISCARD_LO = 16;
    // marker code lengths in chips
    localparam int LONG_CODE_CHIPS = 64;
    localparam int SHORT_CODE_CHIPS = 32;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LEN = 2'b01,
        TX_PAY = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_HUNT = 2'b00,
        RX_LEN = 2'b01,
        RX_PAY = 2'b10
    } rx_state_t;

    typedef enum logic [1:0] {
        FK_MARKER = 2'b00,
        FK_LENGTH = 2'b01,
        FK_PAYLOAD = 2'b10
    } field_kind_t;

    // one field token handed to the modulator
    typedef struct packed {
        logic valid;
        field_kind_t kind;
        logic longCode;
        logic [7:0] data;
    } tx_field_t;

    // marker correlator result, chip error count per half
    typedef struct packed {
        logic strobe;
        logic [4:0] errOne;
        logic [4:0] errTwo;
    } marker_in_t;

    // payload code correlation, one per symbol slot
    typedef struct packed {
        logic strobe;
        logic dataCorr;
    } sym_in_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_t;

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] txLen;
        logic eightBit;
        tx_state_t txSt;
        logic [7:0] txCount;
        tx_field_t txField;
        rx_state_t rxSt;
        logic prevCorr;
        logic [7:0] rxLen;
        logic [7:0] rxCount;
        logic rxLenKnown;
        logic [7:0] discards;
        logic rxStart;
        byte_t rxOut;
        logic [31:0] prdata;
    } state_t;
endpackage

// *** radio_packet_framing.sv ***
// framing control for the radio packet engine with apb registers
// Contract
// - marker enabled: every sent packet starts with a start marker
// - marker enabled: receive only packets with a valid marker, drop rest
// - marker disabled: sent packets carry no start marker
// - marker disabled: receive starts on two consecutive payload correlations
// - long code bit picks 64-chip marker when set, 32-chip when clear
// - length enabled: send transmit length byte right after the marker
// - length enabled: first received byte after marker is packet length
// - length disabled: no length field is sent
// - eight-bit dsss rate always sends length, ignoring the enable bit
// - 64-chip marker: all five threshold bits, applied to each half
`timescale 1ns/1ns
module radio_packet_framing
    import radio_framing_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire byte_t txIn,
    output logic txReady,
    output tx_field_t txField,
    input wire marker_in_t rxMarker,
    input wire sym_in_t rxSym,
    input wire byte_t rxByte,
    input wire logic rxAbort,
    output logic rxStart,
    output byte_t rxOut
);
    state_t st;
    state_t next_st;
    logic setup;
    logic wrAcc;
    logic mapped;
    logic txGo;
    logic markerEn;
    logic longCode;
    logic lenNeeded;
    logic goLen;
    logic [4:0] thEff;
    logic markerOk;
    logic [31:0] readMux;

    // apb decode, zero wait states
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite && mapped;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;
    assign prdata = st.prdata;

    // address decode and read mux
    always_comb begin
        mapped = 1'b1;
        readMux = 32'h0000_0000;
        case (paddr)
            ADDR_CFG: readMux[7:0] = st.cfg;
            ADDR_TXLEN: readMux[7:0] = st.txLen;
            ADDR_CTRL: readMux[CTRL_EIGHT_BIT] = st.eightBit;
            ADDR_STATUS: begin
                readMux[STAT_TX_BUSY] = (st.txSt != TX_IDLE);
                readMux[STAT_RX_ST_LO +: 2] = st.rxSt;
                readMux[STAT_RX_LEN_LO +: 8] = st.rxLen;
                readMux[STAT_DISCARD_LO +: 8] = st.discards;
            end
            default: mapped = 1'b0;
        endcase
    end

    // framing controls taken from the configuration register
    assign markerEn = st.cfg[CFG_MARKER_EN];
    assign longCode = st.cfg[CFG_LONG_CODE];
    // eight-bit rate forces the length field
    assign lenNeeded = st.cfg[CFG_LENGTH_FIELD_ENABLE] || st.eightBit;
    // a go write sets the rate in the same beat, so use its data
    assign goLen = st.cfg[CFG_LENGTH_FIELD_ENABLE] || pwdata[CTRL_EIGHT_BIT];
    assign txGo = wrAcc && (paddr == ADDR_CTRL) && pwdata[CTRL_TX_GO]
        && (st.txSt == TX_IDLE);

    // threshold width follows the marker code length
    assign thEff = longCode ? st.cfg[CFG_TH_HI:0]
        : {1'b0, st.cfg[CFG_TH_HI-1:0]};
    // first half always checked, second half only with the long code, both against the same threshold
    assign markerOk = (rxMarker.errOne <= thEff)
        && (!longCode || (rxMarker.errTwo <= thEff));

    assign txReady = (st.txSt == TX_PAY) && (st.txCount != 8'h00);
    assign txField = st.txField;
    assign rxStart = st.rxStart;
    assign rxOut = st.rxOut;

    // next state of registers, transmit and receive sequencing
    always_comb begin
        next_st = st;
        next_st.txField.valid = 1'b0;
        next_st.rxStart = 1'b0;
        next_st.rxOut.valid = 1'b0;
        if (setup) begin
            next_st.prdata = readMux;
        end
        if (wrAcc) begin
            case (paddr)
                ADDR_CFG: next_st.cfg = pwdata[7:0];
                ADDR_TXLEN: next_st.txLen = pwdata[7:0];
                ADDR_CTRL: next_st.eightBit = pwdata[CTRL_EIGHT_BIT];
                default: ;
            endcase
        end
        // transmit field sequencing
        case (st.txSt)
            TX_IDLE: begin
                if (txGo) begin
                    next_st.txCount = st.txLen;
                    if (markerEn) begin
                        // marker leads the packet
                        next_st.txField = '{1'b1, FK_MARKER, longCode,
                            8'h00};
                        next_st.txSt = goLen ? TX_LEN : TX_PAY;
                    end else if (goLen) begin
                        // no marker, length goes first
                        next_st.txField = '{1'b1, FK_LENGTH, longCode,
                            st.txLen};
                        next_st.txSt = TX_PAY;
                    end else begin
                        // neither marker nor length
                        next_st.txSt = TX_PAY;
                    end
                end
            end
            TX_LEN: begin
                // length byte right after the marker
                next_st.txField = '{1'b1, FK_LENGTH, longCode,
                    st.txCount};
                next_st.txSt = TX_PAY;
            end
            TX_PAY: begin
                if (st.txCount == 8'h00) begin
                    next_st.txSt = TX_IDLE;
                end else if (txIn.valid) begin
                    next_st.txField = '{1'b1, FK_PAYLOAD, longCode,
                        txIn.data};
                    next_st.txCount = st.txCount - 8'h01;
                end
            end
            default: next_st.txSt = TX_IDLE;
        endcase
        // receive framing
        if (rxAbort) begin
            next_st.rxSt = RX_HUNT;
            next_st.prevCorr = 1'b0;
        end else begin
            case (st.rxSt)
                RX_HUNT: begin
                    if (markerEn) begin
                        next_st.prevCorr = 1'b0;
                        // only a valid marker opens a packet
                        if (rxMarker.strobe && markerOk) begin
                            next_st.rxStart = 1'b1;
                        end else if (rxMarker.strobe
                            && (st.discards != 8'hFF)) begin
                            next_st.discards = st.discards + 8'h01;
                        end
                    end else if (rxSym.strobe) begin
                        // two correlations in a row
                        next_st.rxStart = rxSym.dataCorr && st.prevCorr;
                        next_st.prevCorr = rxSym.dataCorr
                            && !st.prevCorr;
                    end
                    if (next_st.rxStart) begin
                        next_st.rxLenKnown = 1'b0;
                        next_st.rxSt = lenNeeded ? RX_LEN : RX_PAY;
                    end
                end
                RX_LEN: begin
                    // first byte after the marker is the length
                    if (rxByte.valid) begin
                        next_st.rxLen = rxByte.data;
                        next_st.rxCount = rxByte.data;
                        next_st.rxLenKnown = 1'b1;
                        next_st.rxSt = (rxByte.data == 8'h00) ? RX_HUNT
                            : RX_PAY;
                    end
                end
                RX_PAY: begin
                    if (rxByte.valid) begin
                        next_st.rxOut = rxByte;
                        if (st.rxLenKnown) begin
                            next_st.rxCount = st.rxCount - 8'h01;
                            if (st.rxCount == 8'h01) begin
                                next_st.rxSt = RX_HUNT;
                            end
                        end
                    end
                end
                default: next_st.rxSt = RX_HUNT;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.cfg <= CFG_RESET;
            st.txLen <= TXLEN_RESET;
            st.txSt <= TX_IDLE;
            st.rxSt <= RX_HUNT;
        end else begin
            st <= next_st;
        end
    end

    // checks on the framing behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_marker_first;
        txGo && markerEn |=> txField.valid && txField.kind == FK_MARKER;
    endproperty
    a_marker_first: assert property (p_marker_first)
        else $error("marker not sent at packet start");

    property p_no_marker;
        txGo && !markerEn |=>
            !(txField.valid && txField.kind == FK_MARKER) [*2];
    endproperty
    a_no_marker: assert property (p_no_marker)
        else $error("marker sent while disabled");

    property p_code_len;
        txGo && markerEn |=> txField.longCode == $past(longCode);
    endproperty
    a_code_len: assert property (p_code_len)
        else $error("marker code length does not match config");

    property p_len_after_marker;
        txGo && markerEn && goLen ##1 1'b1 |=> txField.valid
            && txField.kind == FK_LENGTH && txField.data == $past(st.txCount);
    endproperty
    a_len_after_marker: assert property (p_len_after_marker)
        else $error("length byte does not follow marker");

    property p_no_len;
        txGo && !goLen |=>
            !(txField.valid && txField.kind == FK_LENGTH) [*3];
    endproperty
    a_no_len: assert property (p_no_len)
        else $error("length field sent while disabled");

    property p_eight_bit_len;
        txGo && pwdata[CTRL_EIGHT_BIT] |=> ##[0:1]
            (txField.valid && txField.kind == FK_LENGTH);
    endproperty
    a_eight_bit_len: assert property (p_eight_bit_len)
        else $error("eight-bit rate packet lacks length field");

    property p_bad_marker;
        st.rxSt == RX_HUNT && markerEn && rxMarker.strobe && !markerOk
            && !rxAbort |=> !rxStart && st.rxSt == RX_HUNT;
    endproperty
    a_bad_marker: assert property (p_bad_marker)
        else $error("packet accepted without a valid marker");

    property p_two_corr;
        st.rxSt == RX_HUNT && !markerEn && !rxAbort && rxSym.strobe
            && rxSym.dataCorr && st.prevCorr |=> rxStart;
    endproperty
    a_two_corr: assert property (p_two_corr)
        else $error("reception not started on second correlation");

    property p_rx_len;
        st.rxSt == RX_LEN && rxByte.valid && !rxAbort
            |=> st.rxLen == $past(rxByte.data) && st.rxLenKnown;
    endproperty
    a_rx_len: assert property (p_rx_len)
        else $error("length byte not captured");

    property p_long_halves;
        st.rxSt == RX_HUNT && markerEn && longCode && rxMarker.strobe
            && !rxAbort && rxMarker.errTwo > st.cfg[CFG_TH_HI:0]
            |=> !rxStart;
    endproperty
    a_long_halves: assert property (p_long_halves)
        else $error("second marker half not checked");

    property p_short_th;
        st.rxSt == RX_HUNT && markerEn && !longCode && rxMarker.strobe
            && !rxAbort && rxMarker.errOne[4] |=> !rxStart;
    endproperty
    a_short_th: assert property (p_short_th)
        else $error("short marker used threshold top bit");

    c_tx_full: cover property (txGo && markerEn && lenNeeded);
    c_rx_marker: cover property (rxStart && markerEn);
    c_rx_corr: cover property (rxStart && !markerEn);
    c_discard: cover property (st.discards == 8'h01);
endmodule

// *** radio_packet_framing_tb_top.sv ***
// self-checking bench for the radio packet framing block
`timescale 1ns/1ns
module radio_packet_framing_tb_top
    import radio_framing_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    byte_t txIn = {1'b1, 8'h3C};
    logic txReady;
    tx_field_t txField;
    marker_in_t rxMarker;
    sym_in_t rxSym;
    byte_t rxByte;
    logic rxAbort;
    logic rxStart;
    byte_t rxOut;
    int n_fail = 0;
    int tests_run = 0;
    int nStart = 0;
    logic [7:0] rxq[$];
    logic [31:0] rd;
    logic err;

    always #4 clk_sys = ~clk_sys;

    radio_packet_framing i_radio_packet_framing (.clk_sys, .reset,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .txIn, .txReady, .txField, .rxMarker, .rxSym,
        .rxByte, .rxAbort, .rxStart, .rxOut);

    radio_peer_model i_radio_peer_model (.clk_sys, .txField, .rxMarker,
        .rxSym, .rxByte, .rxAbort);

    // count receive starts and collect delivered payload bytes
    always @(posedge clk_sys) begin
        if (rxStart === 1'b1) begin
            nStart <= nStart + 1;
        end
        if (rxOut.valid === 1'b1) begin
            rxq.push_back(rxOut.data);
        end
    end

    // payload source: next byte after each take, one idle cycle between
    always @(posedge clk_sys) begin
        if (txIn.valid && txReady) begin
            txIn <= {1'b0, txIn.data + 8'h01};
        end else begin
            txIn.valid <= 1'b1;
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(exp, rd);
    endtask

    // configure, start a send and wait until busy clears
    task automatic tx_go(input logic [7:0] cfg, input logic [7:0] len,
            input logic [1:0] ctrl);
        int i;
        apb(1'b1, ADDR_CFG, 32'(cfg));
        apb(1'b1, ADDR_TXLEN, 32'(len));
        i_radio_peer_model.got.delete();
        apb(1'b1, ADDR_CTRL, 32'(ctrl));
        for (i = 0; i < 40; i++) begin
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            if (rd[STAT_TX_BUSY] === 1'b0) break;
        end
        if (i == 40) begin
            n_fail++;
            final_report();
        end
    endtask

    // next logged token: kind, then code length or data
    task automatic tok(input field_kind_t k, input logic [7:0] d);
        tx_field_t t;
        t = i_radio_peer_model.got.pop_front();
        chk(32'(k), 32'(t.kind));
        if (k == FK_MARKER) begin
            chk(32'(d[0]), 32'(t.longCode));
        end else begin
            chk(32'(d), 32'(t.data));
        end
    endtask

    task automatic t_regs();
        rdchk(ADDR_CFG, 32'h0000_00A4);
        rdchk(ADDR_TXLEN, 32'h0000_0000);
        rdchk(ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, 8'h10, 32'h0000_00FF);
        chk(32'h1, 32'(err));
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(32'h1, 32'(err));
        chk(32'h0, rd);
    endtask

    task automatic t_tx();
        tx_go(8'hE0, 8'h02, 2'b10);
        chk(32'h4, 32'(i_radio_peer_model.got.size()));
        tok(FK_MARKER, 8'h01);
        tok(FK_LENGTH, 8'h02);
        tok(FK_PAYLOAD, 8'h3C);
        tok(FK_PAYLOAD, 8'h3D);
        tx_go(8'h80, 8'h01, 2'b10);
        chk(32'h2, 32'(i_radio_peer_model.got.size()));
        tok(FK_MARKER, 8'h00);
        tok(FK_PAYLOAD, 8'h3E);
        tx_go(8'h00, 8'h01, 2'b10);
        chk(32'h1, 32'(i_radio_peer_model.got.size()));
        tok(FK_PAYLOAD, 8'h3F);
        tx_go(8'h00, 8'h01, 2'b11);
        chk(32'h2, 32'(i_radio_peer_model.got.size()));
        tok(FK_LENGTH, 8'h01);
        tok(FK_PAYLOAD, 8'h40);
        rdchk(ADDR_CTRL, 32'h0000_0001);
    endtask

    task automatic t_rx_long();
        int s;
        s = nStart;
        rxq.delete();
        apb(1'b1, ADDR_CFG, 32'h0000_00F0);
        i_radio_peer_model.send_byte(8'h77);
        i_radio_peer_model.marker(5'h10, 5'h11);
        i_radio_peer_model.marker(5'h11, 5'h10);
        repeat (2) @(posedge clk_sys);
        chk(32'h0, 32'(nStart - s));
        rdchk(ADDR_STATUS, 32'h0002_0000);
        i_radio_peer_model.marker(5'h10, 5'h10);
        repeat (2) @(posedge clk_sys);
        chk(32'h1, 32'(nStart - s));
        i_radio_peer_model.send_byte(8'h02);
        i_radio_peer_model.send_byte(8'hA1);
        i_radio_peer_model.send_byte(8'hA2);
        repeat (2) @(posedge clk_sys);
        chk(32'h2, 32'(rxq.size()));
        chk(32'hA1, 32'(rxq[0]));
        chk(32'hA2, 32'(rxq[1]));
        rdchk(ADDR_STATUS, 32'h0002_0200);
    endtask

    task automatic t_rx_short();
        int s;
        s = nStart;
        apb(1'b1, ADDR_CFG, 32'h0000_00B3);
        i_radio_peer_model.marker(5'h04, 5'h00);
        repeat (2) @(posedge clk_sys);
        chk(32'h0, 32'(nStart - s));
        i_radio_peer_model.marker(5'h03, 5'h1F);
        repeat (2) @(posedge clk_sys);
        chk(32'h1, 32'(nStart - s));
        rdchk(ADDR_STATUS, 32'h0003_0204);
        i_radio_peer_model.abort();
    endtask

    task automatic t_rx_plain();
        int s;
        s = nStart;
        rxq.delete();
        apb(1'b1, ADDR_CFG, 32'h0000_0000);
        // leave eight-bit rate, else the first byte is taken as length
        apb(1'b1, ADDR_CTRL, 32'h0000_0000);
        i_radio_peer_model.sym(1'b1);
        i_radio_peer_model.sym(1'b0);
        i_radio_peer_model.sym(1'b1);
        repeat (2) @(posedge clk_sys);
        chk(32'h0, 32'(nStart - s));
        i_radio_peer_model.sym(1'b1);
        repeat (2) @(posedge clk_sys);
        chk(32'h1, 32'(nStart - s));
        i_radio_peer_model.send_byte(8'h5B);
        repeat (2) @(posedge clk_sys);
        chk(32'h5B, 32'(rxq[0]));
        i_radio_peer_model.abort();
    endtask

    // reset, then each scenario in turn
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs();
        t_tx();
        t_rx_long();
        t_rx_short();
        t_rx_plain();
        final_report();
    end
endmodule

// *** radio_peer_model.sv ***
// peer radio model: feeds the receive side and logs sent field tokens
`timescale 1ns/1ns
module radio_peer_model
    import radio_framing_pkg::*;
(
    input wire logic clk_sys,
    input wire tx_field_t txField,
    output marker_in_t rxMarker,
    output sym_in_t rxSym,
    output byte_t rxByte,
    output logic rxAbort
);
    tx_field_t got[$];

    // log every field token put on the air
    always @(posedge clk_sys) begin
        if (txField.valid === 1'b1) begin
            got.push_back(txField);
        end
    end

    // quiet air after power-up
    initial begin
        rxMarker = '0;
        rxSym = '0;
        rxByte = '0;
        rxAbort = 1'b0;
    end

    // one marker correlation, error counts of both halves
    task automatic marker(input logic [4:0] e1, input logic [4:0] e2);
        @(posedge clk_sys);
        rxMarker <= {1'b1, e1, e2};
        @(posedge clk_sys);
        rxMarker <= {1'b0, ~e1, ~e2}; // stale counts are not held
    endtask

    // one symbol slot with or without a payload code hit
    task automatic sym(input logic c);
        @(posedge clk_sys);
        rxSym <= {1'b1, c};
        @(posedge clk_sys);
        rxSym <= {1'b0, ~c};
    endtask

    // one received byte
    task automatic send_byte(input logic [7:0] d);
        @(posedge clk_sys);
        rxByte <= {1'b1, d};
        @(posedge clk_sys);
        rxByte <= {1'b0, ~d};
    endtask

    // carrier lost for one cycle
    task automatic abort();
        @(posedge clk_sys);
        rxAbort <= 1'b1;
        @(posedge clk_sys);
        rxAbort <= 1'b0;
    endtask
endmodule
